// ===== mbsrv_consts.svh
/*
  Constants of the byte-stream request server: frame positions, function
  and exception codes, limits, item offsets and action values.
  Assumes inclusion by bare name from the design modules.
*/
`ifndef MBSRV_CONSTS_SVH
`define MBSRV_CONSTS_SVH

// byte positions within a request frame
`define MBSRV_IDX_TAG_HI   17'd0
`define MBSRV_IDX_TAG_LO   17'd1
`define MBSRV_IDX_PID_HI   17'd2
`define MBSRV_IDX_PID_LO   17'd3
`define MBSRV_IDX_LEN_HI   17'd4
`define MBSRV_IDX_LEN_LO   17'd5
`define MBSRV_IDX_UNIT     17'd6
`define MBSRV_IDX_FC       17'd7
`define MBSRV_IDX_ADR_HI   17'd8
`define MBSRV_IDX_ADR_LO   17'd9
`define MBSRV_IDX_QTY_HI   17'd10
`define MBSRV_IDX_QTY_LO   17'd11
`define MBSRV_IDX_BCNT     17'd12
`define MBSRV_IDX_DAT0     17'd13
`define MBSRV_IDX_DAT1     17'd14
`define MBSRV_LEN_TAIL     17'd5
`define MBSRV_LEN_MIN      16'd2
`define MBSRV_PID_MODBUS   16'h0000

// function codes
`define MBSRV_FC_RD_COILS  8'h01
`define MBSRV_FC_RD_INPUTS 8'h02
`define MBSRV_FC_RD_HOLD   8'h03
`define MBSRV_FC_RD_INREG  8'h04
`define MBSRV_FC_WR_COIL   8'h05
`define MBSRV_FC_WR_COILS  8'h0F
`define MBSRV_FC_WR_REGS   8'h10

// exception codes
`define MBSRV_EX_NONE      8'h00
`define MBSRV_EX_FUNC      8'h01
`define MBSRV_EX_ADDR      8'h02
`define MBSRV_EX_VALUE     8'h03

// quantity limits and expected lengths
`define MBSRV_MAX_RD_BITS  16'h07D0
`define MBSRV_MAX_RD_REGS  16'h007D
`define MBSRV_MAX_WR_BITS  16'h07B0
`define MBSRV_MAX_WR_REGS  16'h007B
`define MBSRV_LEN_FIXED    16'h0006
`define MBSRV_LEN_WR_BASE  16'h0007
`define MBSRV_COIL_ON      16'hFF00
`define MBSRV_COIL_OFF     16'h0000

// item offsets and reference bases
`define MBSRV_NUM_COILS    17'd16
`define MBSRV_COIL_OFS     16'h0001
`define MBSRV_COIL_BASE    16'h0001
`define MBSRV_SYSCTL_OFS   16'h9D38
`define MBSRV_HOLD_BASE    16'h9C41
`define MBSRV_COIL_RST     16'h0000

// system-control values and response lengths
`define MBSRV_SYS_RESET    16'h0001
`define MBSRV_SYS_FACTORY  16'h00F7
`define MBSRV_RLEN_EXC     16'h0003
`define MBSRV_RLEN_RDBITS  16'h0005
`define MBSRV_RLEN_ECHO    16'h0006
`define MBSRV_RD_BCOUNT    8'h02

`endif

// ===== mbsrv_pkg.sv
/*
  Types of the request server: states and frame field carriers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mbsrv_pkg;

  typedef enum logic [1:0] {st_rx, st_exec, st_send} mbsrv_state_t;

  // application protocol header, in wire order
  typedef struct packed {
    logic [15:0] transaction_tag;
    logic [15:0] protocol_identifier;
    logic [15:0] len;
    logic [7:0]  slave_unit_identifier;
  } mbsrv_hdr_t;

  // request body fields
  typedef struct packed {
    logic [7:0]  function_code_field;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [7:0]  bcount;
    logic [7:0]  dat0;
    logic [7:0]  dat1;
  } mbsrv_req_t;

endpackage : mbsrv_pkg

// ===== mbsrv_tx_shift.sv
/*
  Response byte sender: loads a whole frame, sends it most significant
  byte first with valid/ready, pulses done after the last byte.
  Assumes load is only raised while idle.
*/
module mbsrv_tx_shift
  import mbsrv_pkg::*;
#(
  parameter int NBYTES = 12,
  parameter int CW     = $clog2(NBYTES + 1)
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire logic                load,
  input  wire logic [8*NBYTES-1:0] frame,
  input  wire logic [CW-1:0]       nbytes,
  input  wire logic                tx_ready,
  output logic                     tx_valid,
  output logic [7:0]               tx_data,
  output logic                     done
);

  logic [8*NBYTES-1:0] sh_reg;
  logic [CW-1:0]       cnt_reg;
  logic                valid_reg;
  logic                done_reg;
  wire                 adv  = valid_reg && tx_ready;
  wire                 tail = (cnt_reg == CW'(1));

  // shift out; the receiver may stall us at any byte
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_reg    <= '0;
      cnt_reg   <= '0;
      valid_reg <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= adv && tail;
      if (load) begin
        sh_reg    <= frame;
        cnt_reg   <= nbytes;
        valid_reg <= (nbytes != '0);
      end else if (adv) begin
        sh_reg    <= sh_reg << 8;
        cnt_reg   <= cnt_reg - CW'(1);
        valid_reg <= !tail;
      end
    end
  end

  assign tx_valid = valid_reg;
  assign tx_data  = sh_reg[8*NBYTES-1 -: 8];
  assign done     = done_reg;

endmodule : mbsrv_tx_shift

// ===== mbsrv_io_server.sv
/*
  Request server of a digital output module: takes request frames as a
  byte stream, executes them on sixteen output coils and a system-control
  register, and returns a normal or exception response frame.
  Assumes the transport below delivers frame bytes in order, synchronous
  to ref_clk, and takes response bytes with valid/ready.
  Assumes one frame in flight: the next request waits for rx_ready.
  Assumes the system acts on the one-cycle reset and restore pulses.
  Assumes the coil outputs are wired straight to the output drivers.
*/
// Overview of operation
// - only the client starts; one reply per query, never unsolicited
// - each frame opens with a seven-byte header in fixed field order
// - response header repeats the request transaction tag unchanged
// - length counts bytes after it, unit byte included; delimits frames
// - unit identifier is taken from request and returned in response
// - function code is one byte; codes 128 and above are exceptions
// - seven function codes are served: 1, 2, 3, 4, 5, 15, 16
// - unsupported code, excess quantity or absent item gives an error
// - a normal response echoes the request function code, then data
// - an exception response returns the code with its top bit set
// - an exception response carries an exception code as its data
// - request data holds address, quantity and, for multi-item writes, byte count
// - multi-byte addresses and quantities travel high byte first
// - coil reads pack bits into a 16-bit word, high byte first
// - register reads return 16-bit items, high byte first; here every register read with valid length and quantity is refused with an address error
`include "mbsrv_consts.svh"

module mbsrv_io_server
  import mbsrv_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             rx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  output logic [15:0]      coil_out,
  output logic             sys_reset_req,
  output logic             factory_restore_req
);

  // ****************************************************************
  // state and storage
  // ****************************************************************

  mbsrv_state_t state_reg;
  mbsrv_state_t state_next;
  mbsrv_hdr_t   hdr_reg;
  mbsrv_req_t   req_reg;
  logic [16:0]  idx_reg;
  logic [15:0]  coil_reg;
  logic [15:0]  coil_next;
  logic         rx_ready_reg;
  logic         sys_reset_reg;
  logic         factory_reg;
  logic         tx_done;

  // ****************************************************************
  // request intake
  // ****************************************************************

  // request frame as it arrives, one byte per taken beat:
  //   0-1   transaction tag      2-3   protocol identifier
  //   4-5   length               6     slave unit identifier
  //   7     function code        8-9   item address
  //   10-11 quantity or value    12    byte count (writes)
  //   13-14 first data bytes; anything later is only counted

  // a byte is taken only while listening; responses block intake
  wire         take     = rx_valid && rx_ready_reg;
  wire [16:0]  len_end  = {1'b0, hdr_reg.len} + `MBSRV_LEN_TAIL;
  wire         at_unit  = (idx_reg == `MBSRV_IDX_UNIT);
  // the length is known from byte 6 on, so the end test only
  // looks from the unit byte on
  // a length below two cannot hold a function code: end at unit byte
  wire         last_byte = take && (at_unit ?
                           (hdr_reg.len < `MBSRV_LEN_MIN) :
                           (idx_reg > `MBSRV_IDX_UNIT &&
                            idx_reg == len_end));

  // byte index within the frame; 17 bits so a huge length never wraps
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      idx_reg <= 17'h00000;
    end else if (take) begin
      idx_reg <= last_byte ? 17'h00000 : idx_reg + 17'h00001;
    end
  end

  // header fields, high byte first
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hdr_reg <= '0;
    end else if (take) begin
      unique case (idx_reg)
        `MBSRV_IDX_TAG_HI: hdr_reg.transaction_tag[15:8] <= rx_data;
        `MBSRV_IDX_TAG_LO: hdr_reg.transaction_tag[7:0]  <= rx_data;
        `MBSRV_IDX_PID_HI: hdr_reg.protocol_identifier[15:8] <= rx_data;
        `MBSRV_IDX_PID_LO: hdr_reg.protocol_identifier[7:0] <= rx_data;
        `MBSRV_IDX_LEN_HI: hdr_reg.len[15:8] <= rx_data;
        `MBSRV_IDX_LEN_LO: hdr_reg.len[7:0]  <= rx_data;
        `MBSRV_IDX_UNIT:   hdr_reg.slave_unit_identifier <= rx_data;
        default: ;
      endcase
    end
  end

  // body fields; bytes past the second data byte are counted only
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_reg <= '0;
    end else if (take) begin
      unique case (idx_reg)
        `MBSRV_IDX_FC:     req_reg.function_code_field <= rx_data;
        `MBSRV_IDX_ADR_HI: req_reg.addr[15:8] <= rx_data;
        `MBSRV_IDX_ADR_LO: req_reg.addr[7:0]  <= rx_data;
        `MBSRV_IDX_QTY_HI: req_reg.qty[15:8]  <= rx_data;
        `MBSRV_IDX_QTY_LO: req_reg.qty[7:0]   <= rx_data;
        `MBSRV_IDX_BCNT:   req_reg.bcount     <= rx_data;
        `MBSRV_IDX_DAT0:   req_reg.dat0       <= rx_data;
        `MBSRV_IDX_DAT1:   req_reg.dat1       <= rx_data;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // request decode and checks
  // ****************************************************************

  wire [7:0]  fc        = req_reg.function_code_field;
  wire        fc_rbits  = (fc == `MBSRV_FC_RD_COILS) ||
                          (fc == `MBSRV_FC_RD_INPUTS);
  wire        fc_rregs  = (fc == `MBSRV_FC_RD_HOLD) ||
                          (fc == `MBSRV_FC_RD_INREG);
  wire        fc_wcoil  = (fc == `MBSRV_FC_WR_COIL);
  wire        fc_wcoils = (fc == `MBSRV_FC_WR_COILS);
  wire        fc_wregs  = (fc == `MBSRV_FC_WR_REGS);
  // codes with the top bit set fall out here as unknown
  wire        fc_known  = fc_rbits || fc_rregs || fc_wcoil ||
                          fc_wcoils || fc_wregs;

  // item positions relative to the first coil and the control word
  wire [15:0] coil_first = `MBSRV_COIL_OFS - `MBSRV_COIL_BASE;
  wire [15:0] sysctl_adr = `MBSRV_SYSCTL_OFS - `MBSRV_HOLD_BASE;
  wire [15:0] rel_addr   = req_reg.addr - coil_first;
  wire [16:0] coil_end   = {1'b0, rel_addr} + {1'b0, req_reg.qty};
  wire        span_ok    = (coil_end <= `MBSRV_NUM_COILS);
  wire        one_ok     = ({1'b0, rel_addr} < `MBSRV_NUM_COILS);

  // byte count that the quantity implies
  wire [16:0] bits_bytes = ({1'b0, req_reg.qty} + 17'h00007) >> 3;
  wire [16:0] regs_bytes = {req_reg.qty, 1'b0};
  wire [16:0] bcount_w   = {9'h000, req_reg.bcount};

  // expected length field for the function
  wire [15:0] len_exp = (fc_wcoils || fc_wregs) ?
                        `MBSRV_LEN_WR_BASE + {8'h00, req_reg.bcount} :
                        `MBSRV_LEN_FIXED;
  wire        len_bad = (hdr_reg.len != len_exp);

  wire        qty_zero  = (req_reg.qty == 16'h0000);
  wire        coil_word = (req_reg.qty == `MBSRV_COIL_ON) ||
                          (req_reg.qty == `MBSRV_COIL_OFF);
  // quantity limits keep every request and reply inside one frame
  // too much data, or a malformed value, per function
  wire        qty_bad =
    fc_rbits  ? (qty_zero || req_reg.qty > `MBSRV_MAX_RD_BITS) :
    fc_rregs  ? (qty_zero || req_reg.qty > `MBSRV_MAX_RD_REGS) :
    fc_wcoil  ? !coil_word :
    fc_wcoils ? (qty_zero || req_reg.qty > `MBSRV_MAX_WR_BITS ||
                 bcount_w != bits_bytes) :
    fc_wregs  ? (qty_zero || req_reg.qty > `MBSRV_MAX_WR_REGS ||
                 bcount_w != regs_bytes) :
    1'b0;

  // absent items: no inputs, no input registers, and the control
  // word is write-only, so those reads always miss
  wire        addr_bad =
    (fc == `MBSRV_FC_RD_COILS) ? !span_ok :
    fc_wcoil  ? !one_ok :
    fc_wcoils ? !span_ok :
    fc_wregs  ? !(req_reg.addr == sysctl_adr &&
                  req_reg.qty == 16'h0001) :
    1'b1;

  // outcome per function once the code is known:
  //   01      span of coils present, else address error
  //   02, 04  no such items here, an address error once length and quantity are valid
  //   03      the control word cannot be read back
  //   05      value must be all-on or all-off
  //   0F      byte count must match the quantity
  //   10      only the control word, one register at a time
  // checks in the customary order: function, value, address
  wire [7:0]  exc_code = !fc_known          ? `MBSRV_EX_FUNC  :
                         (len_bad || qty_bad) ? `MBSRV_EX_VALUE :
                         addr_bad           ? `MBSRV_EX_ADDR  :
                         `MBSRV_EX_NONE;
  wire        exc      = (exc_code != `MBSRV_EX_NONE);

  // frames of a foreign protocol or with no function code are dropped
  wire        drop = (hdr_reg.protocol_identifier != `MBSRV_PID_MODBUS) ||
                     (hdr_reg.len < `MBSRV_LEN_MIN);
  wire        exec_ok = (state_reg == st_exec) && !drop && !exc;

  // ****************************************************************
  // coil bank and system control
  // ****************************************************************

  // a write lands on the exec edge, together with the first reply
  // byte; the outputs never see a half-written bank
  // mask of qty bits; qty is at most sixteen once checks pass
  wire [16:0] mask_w   = (17'h00001 << req_reg.qty[4:0]) - 17'h00001;
  wire [15:0] mask16   = fc_wcoil ? 16'h0001 : mask_w[15:0];
  // first data byte carries the lowest-addressed coils
  wire [15:0] wr_bits  = fc_wcoil ?
                         {16{req_reg.qty == `MBSRV_COIL_ON}} :
                         {req_reg.dat1, req_reg.dat0};
  wire [15:0] coil_mrg = (coil_reg & ~(mask16 << rel_addr[3:0])) |
                         ((wr_bits & mask16) << rel_addr[3:0]);
  wire        do_wcoil = exec_ok && (fc_wcoil || fc_wcoils);
  // per coil: take the merged bit only on an accepted write
  for (genvar i = 0; i < 16; i++) begin : g_coil
    assign coil_next[i] = do_wcoil ? coil_mrg[i] : coil_reg[i];
  end

  // the write is echoed whatever its value; only 1 and 247 act
  // control word arrives high byte first
  wire [15:0] sys_word = {req_reg.dat0, req_reg.dat1};
  wire        do_sys   = exec_ok && fc_wregs;
  wire        sys_rst  = do_sys && (sys_word == `MBSRV_SYS_RESET);
  wire        sys_fact = do_sys && (sys_word == `MBSRV_SYS_FACTORY);

  // coils hold their state; outputs follow the register directly
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      coil_reg <= `MBSRV_COIL_RST;
    end else begin
      coil_reg <= coil_next;
    end
  end

  // one-cycle requests to the system; other values do nothing
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_reset_reg <= 1'b0;
      factory_reg   <= 1'b0;
    end else begin
      sys_reset_reg <= sys_rst;
      factory_reg   <= sys_fact;
    end
  end

  // ****************************************************************
  // response build
  // ****************************************************************

  // coil read: requested coils from bit 0 up, unused bits zero
  wire [15:0] rd_word = (coil_reg >> rel_addr[3:0]) & mask_w[15:0];
  wire        rd_bits = (fc == `MBSRV_FC_RD_COILS);

  // echo or flagged function code
  wire [7:0]  resp_fc = exc ? {1'b1, fc[6:0]} : fc;
  wire [31:0] payload =
    exc     ? {exc_code, 24'h000000} :
    rd_bits ? {`MBSRV_RD_BCOUNT, rd_word, 8'h00} :
    {req_reg.addr, req_reg.qty};
  wire [15:0] rlen = exc     ? `MBSRV_RLEN_EXC :
                     rd_bits ? `MBSRV_RLEN_RDBITS :
                     `MBSRV_RLEN_ECHO;
  // reply frame, byte by byte:
  //   0-1   tag copied from the request
  //   2-3   protocol identifier, always zero
  //   4-5   length: unit, code and data bytes
  //   6     unit copied from the request
  //   7     echoed or flagged function code
  //   8-11  exception code, or count and coil word, or address and qty
  // unused tail bytes are never sent; the byte count stops short of them
  // whole frame, most significant byte goes out first
  wire [95:0] resp_frame = {hdr_reg.transaction_tag,
                            `MBSRV_PID_MODBUS,
                            rlen,
                            hdr_reg.slave_unit_identifier,
                            resp_fc,
                            payload};
  wire [3:0]  resp_bytes = rlen[3:0] + 4'h6;
  wire        tx_load    = (state_reg == st_exec) && !drop;

  // the sender keeps its own copy of the frame, so request fields
  // may change freely once it has been loaded
  mbsrv_tx_shift #(
    .NBYTES (12)
  ) mbsrv_tx_shift_i (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .load     (tx_load),
    .frame    (resp_frame),
    .nbytes   (resp_bytes),
    .tx_ready (tx_ready),
    .tx_valid (tx_valid),
    .tx_data  (tx_data),
    .done     (tx_done)
  );

  // ****************************************************************
  // sequencing
  // ****************************************************************

  // a dropped frame skips the reply, so the client sees only its
  // own timeout; at most one reply per frame keeps tags in step
  // listen, execute for one cycle, then send one reply unless the frame is dropped
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      st_rx:   if (last_byte) state_next = st_exec;
      st_exec: state_next = drop ? st_rx : st_send;
      st_send: if (tx_done) state_next = st_rx;
      default: state_next = st_rx;                                 // unused code
    endcase
  end

  // ready is registered, so it drops on the frame's last byte
  // the next frame may follow at once; no gap is needed
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= st_rx;
      rx_ready_reg <= 1'b1;
    end else begin
      state_reg    <= state_next;
      rx_ready_reg <= (state_next == st_rx);
    end
  end

  assign rx_ready            = rx_ready_reg;
  assign coil_out            = coil_reg;
  assign sys_reset_req       = sys_reset_reg;
  assign factory_restore_req = factory_reg;

endmodule : mbsrv_io_server

// ===== mbsrv_io_server_properties.sv
/*
  Checker of the request server port timing and pulse behaviour.
  Assumes binding to mbsrv_io_server and a single ref_clk domain.
*/
module mbsrv_io_server_properties (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_data,
  input wire logic        rx_ready,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_ready,
  input wire logic [15:0] coil_out,
  input wire logic        sys_reset_req,
  input wire logic        factory_restore_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // ****************
  // helper logic
  // ****************
  logic [7:0] tx_idx_reg;

  // position of the response byte on offer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) tx_idx_reg <= 8'h00;
    else if (!tx_valid) tx_idx_reg <= 8'h00;
    else if (tx_ready) tx_idx_reg <= tx_idx_reg + 8'h01;
  end

  // ****************
  // assertions
  // ****************
  a_no_unsolicited: assert property (
    tx_valid |-> !rx_ready) else $error("reply while listening");
  a_reply_bound: assert property (
    $fell(rx_ready) |-> ##[1:3] (tx_valid || rx_ready))
    else $error("no reply after request");
  a_tx_byte_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("response byte lost before taken");
  a_pid_len_zero: assert property (
    tx_valid && tx_idx_reg inside {8'h02, 8'h03, 8'h04} |-> tx_data == 8'h00)
    else $error("protocol_identifier or length high byte not zero");
  a_ready_return: assert property (
    $fell(tx_valid) |-> ##[0:1] rx_ready) else $error("rx not reopened");
  a_coil_at_exec: assert property (
    $changed(coil_out) |-> $rose(tx_valid)) else $error("coil change off exec");
  a_pulse_single: assert property (
    sys_reset_req || factory_restore_req |=>
      !sys_reset_req && !factory_restore_req) else $error("pulse too long");
  a_pulse_exclusive: assert property (
    (sys_reset_req || factory_restore_req) |->
      $rose(tx_valid) && !(sys_reset_req && factory_restore_req))
    else $error("pulse off exec or both pulses");

  c_reset_pulse: cover property (sys_reset_req);
  c_factory_pulse: cover property (factory_restore_req);
  c_coil_change: cover property ($changed(coil_out));
  c_stalled_tx: cover property (tx_valid && !tx_ready);
endmodule : mbsrv_io_server_properties

bind mbsrv_io_server mbsrv_io_server_properties chk_i (.*);

// ===== mbsrv_client_model.sv
/*
  Remote client model: frames requests with the header, collects reply.
  Assumes the bench calls send and reads resp; slow makes the sink stall.
*/
module mbsrv_client_model (
  input wire logic  ref_clk,
  output logic      rx_valid,
  output logic [7:0] rx_data,
  input wire logic  rx_ready,
  input wire logic  tx_valid,
  input wire logic [7:0] tx_data,
  output logic      tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] resp[$];
  logic       slow;
  logic [15:0] pid;

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b1;
    slow     = 1'b0;
    pid      = 16'h0000;
  end

  // sink: take bytes, stall every other cycle when slow
  always @(posedge ref_clk) begin
    if (tx_valid === 1'b1 && tx_ready) resp.push_back(tx_data);
    #1 tx_ready = slow ? ~tx_ready : 1'b1;
  end

  // only the client opens a transaction, one frame per call
  task automatic send(input logic [15:0] tag, input logic [7:0] unit, fc,
                      input logic [7:0] body[$]);
    logic [15:0] len;
    logic [7:0]  f[$];
    len = 16'(body.size() + 2);
    f = {tag[15:8], tag[7:0], pid[15:8], pid[7:0], len[15:8], len[7:0],
         unit, fc, body};
    foreach (f[i]) begin
      rx_valid = 1'b1;
      rx_data  = f[i];
      do @(posedge ref_clk); while (rx_ready !== 1'b1);
      #1;
    end
    rx_valid = 1'b0;
    rx_data  = ~rx_data; // released line shows no stale value
  endtask : send
endmodule : mbsrv_client_model

// ===== mbsrv_io_server_test.sv
/*
  Self-checking bench of the request server: writes, reads, exceptions.
  Assumes the client model drives the request and response streams.
*/
module mbsrv_io_server_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0]  rx_data, tx_data;
  logic [15:0] coil_out;
  logic        sys_reset_req, factory_restore_req;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          rst_pulses = 0;
  int          fac_pulses = 0;
  logic [15:0] tag = 16'h1234;
  logic [7:0]  unit = 8'h11;
  // fc, address, quantity of each refused request and its exception code
  logic [39:0] ex_req [8] = '{40'h07_0000_0001, 40'h81_0000_0001,
    40'h01_0000_0000, 40'h01_0010_0001, 40'h03_0000_0001,
    40'h02_0000_0001, 40'h04_0000_0001, 40'h05_0003_1234};
  logic [7:0]  ex_code [8] = '{8'h01, 8'h01, 8'h03, 8'h02, 8'h02, 8'h02,
    8'h02, 8'h03};

  always #50 ref_clk = ~ref_clk;

  mbsrv_io_server mbsrv_io_server_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .coil_out(coil_out), .sys_reset_req(sys_reset_req),
    .factory_restore_req(factory_restore_req));
  mbsrv_client_model cl_i (.ref_clk(ref_clk), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));

  // ****************
  // pulse counting and hang guard
  // ****************
  always @(posedge ref_clk) begin
    if (sys_reset_req === 1'b1) rst_pulses++;
    if (factory_restore_req === 1'b1) fac_pulses++;
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one transaction; expected header built from the sent tag and unit
  task automatic xact(input logic [7:0] fc, input logic [7:0] body[$],
                      input logic [7:0] pdu[$]);
    logic [7:0] e[$];
    int         k;
    tag  = tag + 16'h0111;
    unit = unit + 8'h01;
    e = {tag[15:8], tag[7:0], 8'h00, 8'h00, 8'h00, 8'(pdu.size() + 1),
         unit, pdu};
    cl_i.resp.delete();
    cl_i.send(tag, unit, fc, body);
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (rx_ready !== 1'b1 && k < 300);
    #1;
    chk(16'(cl_i.resp.size()), 16'(e.size()));
    for (int i = 0; i < e.size() && i < cl_i.resp.size(); i++) begin
      chk({8'h00, cl_i.resp[i]}, {8'h00, e[i]});
    end
  endtask : xact

  task automatic finish_test();
    if (n_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    chk(coil_out, 16'h0000);
    xact(8'h05, '{8'h00, 8'h03, 8'hFF, 8'h00},
         '{8'h05, 8'h00, 8'h03, 8'hFF, 8'h00});
    chk(coil_out, 16'h0008);
    xact(8'h0F, '{8'h00, 8'h00, 8'h00, 8'h10, 8'h02, 8'hA5, 8'h5A},
         '{8'h0F, 8'h00, 8'h00, 8'h00, 8'h10});
    chk(coil_out, 16'h5AA5);
    cl_i.slow = 1'b1; // stalling sink for the reads and the control writes
    xact(8'h01, '{8'h00, 8'h00, 8'h00, 8'h10},
         '{8'h01, 8'h02, 8'h5A, 8'hA5});
    xact(8'h01, '{8'h00, 8'h04, 8'h00, 8'h04},
         '{8'h01, 8'h02, 8'h00, 8'h0A});
    xact(8'h10, '{8'h00, 8'hF7, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01},
         '{8'h10, 8'h00, 8'hF7, 8'h00, 8'h01});
    xact(8'h10, '{8'h00, 8'hF7, 8'h00, 8'h01, 8'h02, 8'h00, 8'hF7},
         '{8'h10, 8'h00, 8'hF7, 8'h00, 8'h01});
    xact(8'h10, '{8'h00, 8'hF7, 8'h00, 8'h01, 8'h02, 8'h00, 8'h05},
         '{8'h10, 8'h00, 8'hF7, 8'h00, 8'h01});
    chk(16'(rst_pulses), 16'h0001);
    chk(16'(fac_pulses), 16'h0001);
    cl_i.slow = 1'b0;
    // foreign protocol identifier: frame dropped, coil 1 stays off
    cl_i.pid = 16'h0001;
    cl_i.resp.delete();
    cl_i.send(tag, unit, 8'h05, '{8'h00, 8'h01, 8'hFF, 8'h00});
    repeat (20) @(posedge ref_clk);
    #1 cl_i.pid = 16'h0000;
    chk(16'(cl_i.resp.size()), 16'h0000);
    // refused requests: top bit set on the code, exception code as data
    foreach (ex_req[j]) begin
      xact(ex_req[j][39:32], '{ex_req[j][31:24], ex_req[j][23:16],
           ex_req[j][15:8], ex_req[j][7:0]},
           '{ex_req[j][39:32] | 8'h80, ex_code[j]});
    end
    xact(8'h05, '{8'h00, 8'h00, 8'h00, 8'h00},
         '{8'h05, 8'h00, 8'h00, 8'h00, 8'h00});
    chk(coil_out, 16'h5AA4);
    finish_test();
  end
endmodule : mbsrv_io_server_test
